// ---- aop_pkg.sv ----
// Package for the result output port configuration block.
// Assumes a 250 MHz system clock.
package aop_pkg;

	localparam int CLK_PERIOD_NS = 4;
	localparam int RESULT_W = 16;

	// Least serial clock periods for divider codes 00, 01, 10, 11
	localparam int SCLK_MIN_PERIOD_NS_00 = 30;
	localparam int SCLK_MIN_PERIOD_NS_01 = 60;
	localparam int SCLK_MIN_PERIOD_NS_10 = 120;
	localparam int SCLK_MIN_PERIOD_NS_11 = 240;
	localparam logic [4:0] SCLK_HALF_CYC_00 =
		5'((SCLK_MIN_PERIOD_NS_00 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] SCLK_HALF_CYC_01 =
		5'((SCLK_MIN_PERIOD_NS_01 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] SCLK_HALF_CYC_10 =
		5'((SCLK_MIN_PERIOD_NS_10 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] SCLK_HALF_CYC_11 =
		5'((SCLK_MIN_PERIOD_NS_11 / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [4:0] BIT_COUNT = 5'h10;

	// Positions in the synchronised pin vector
	localparam int PIN_SER = 0;
	localparam int PIN_BYTE = 1;
	localparam int PIN_CODE = 2;
	localparam int PIN_RDC = 3;
	localparam int PIN_CS_N = 4;
	localparam int PIN_XCLK = 5;
	localparam int PIN_DIV0 = 6;
	localparam int PIN_DIV1 = 7;
	localparam int PIN_SRC = 8;
	localparam int PIN_N = 9;

	// Bus lanes with special roles
	localparam int LANE_SERIAL_RESULT_OUT = 8;
	localparam logic [15:0] OE_RESET = 16'h0003;
	localparam logic [15:0] OE_SERIAL = 16'h0003;
	localparam logic [15:0] OE_ALL = 16'hFFFF;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_MASTER = 3'b010,
		ST_SLAVE = 3'b100
	} aop_state_t;

	typedef struct packed
	{
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] s3;
		logic [PIN_N-1:0] filt;
		logic [PIN_N-1:0] filt_prev;
		logic busy_prev;
		logic [15:0] held;
		logic [15:0] shreg;
		logic [4:0] bit_cnt;
		logic [4:0] div_cnt;
		logic [4:0] half;
		logic sclk;
		aop_state_t fsm;
		logic [15:0] bus_out;
		logic [15:0] bus_oe;
		logic sclk_oe;
	} aop_regs_t;

endpackage : aop_pkg

// ---- aop_port.sv ----
// Result output port of a sampling converter: parallel bus or serial port.
// Assumes the converter core on clk_in; config pins and host clock arrive asynchronously.
// Contract
// R1: Select low gives parallel bus output; high gives serial modes.
// R2: Serial modes reuse some bus pins; other output pins go high impedance.
// R3: Byte order high puts low byte on upper lanes; low reverses that.
// R4: Coding high gives straight binary; low inverts the MSB for twos complement.
// R5: Bus bits 0 and 1 are always outputs.
// R6: Bits 2 to 4 output data in parallel, become config inputs in serial.
// R7: Master read-after-convert uses divider select to slow the internal serial clock.
// R8: Other serial modes leave the divider pins undriven.
// R9: Serial with clock source low: device drives its serial clock out.
// R10: Clock source high: host clocks data, gated by chip select.
// R11: Internal clock period least 30, 60, 120, 240 ns by divider code.
// R12: Master: read-during-convert sends previous result during conversion, else after.
// R13: Result shifts out on serial data, MSB first.
// R14: Host changes selects only while no result transfer runs.
`timescale 1ns/10ps
`default_nettype none

module aop_port
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic enable_in,
	input wire logic serial_parallel_select_in,
	input wire logic byte_order_select_in,
	input wire logic output_coding_select_in,
	input wire logic read_during_convert_select_in,
	input wire logic chip_select_n_in,
	input wire logic [15:0] result_in,
	input wire logic result_valid_in,
	input wire logic conversion_busy_in,
	input wire logic [15:0] data_bus_in,
	output logic [15:0] data_bus_out,
	output logic [15:0] data_bus_oe_out,
	input wire logic serial_result_clock_in,
	output logic serial_result_clock_out,
	output logic serial_result_clock_oe_out
);

	aop_pkg::aop_regs_t st;
	aop_pkg::aop_regs_t next_st;
	logic [aop_pkg::PIN_N-1:0] pins;
	logic [aop_pkg::PIN_N-1:0] agree;
	logic ser;
	logic master;
	logic busy_rise;
	logic cs_fall;
	logic xclk_rise;
	logic [15:0] coded;

	assign pins = {data_bus_in[4], data_bus_in[3], data_bus_in[2], serial_result_clock_in,
		chip_select_n_in, read_during_convert_select_in, output_coding_select_in,
		byte_order_select_in, serial_parallel_select_in};
	assign agree = ~(st.s2 ^ st.s3);
	assign ser = st.filt[aop_pkg::PIN_SER];
	assign master = ser & ~st.filt[aop_pkg::PIN_SRC];
	assign busy_rise = conversion_busy_in & ~st.busy_prev;
	assign cs_fall = st.filt_prev[aop_pkg::PIN_CS_N] & ~st.filt[aop_pkg::PIN_CS_N];
	assign xclk_rise = ~st.filt_prev[aop_pkg::PIN_XCLK] & st.filt[aop_pkg::PIN_XCLK];
	assign coded = {result_in[15] ^ ~st.filt[aop_pkg::PIN_CODE], result_in[14:0]}; // R4

	always_comb
	begin
		next_st = st;
		if (enable_in)
		begin
			// Pin changes count once the second and third stages agree
			next_st.s1 = pins;
			next_st.s2 = st.s1;
			next_st.s3 = st.s2;
			next_st.filt = (agree & st.s3) | (~agree & st.filt);
			next_st.filt_prev = st.filt;
			next_st.busy_prev = conversion_busy_in;
			if (result_valid_in)
			begin
				next_st.held = coded; // R4
			end

			// Divider code only applies in master read-after-convert
			if (st.filt[aop_pkg::PIN_RDC])
			begin
				next_st.half = aop_pkg::SCLK_HALF_CYC_00; // R8
			end
			else
			begin
				unique case ({st.filt[aop_pkg::PIN_DIV1], st.filt[aop_pkg::PIN_DIV0]}) // R7 R11
					2'b00: next_st.half = aop_pkg::SCLK_HALF_CYC_00;
					2'b01: next_st.half = aop_pkg::SCLK_HALF_CYC_01;
					2'b10: next_st.half = aop_pkg::SCLK_HALF_CYC_10;
					2'b11: next_st.half = aop_pkg::SCLK_HALF_CYC_11;
				endcase
			end

			unique case (st.fsm)
				aop_pkg::ST_IDLE:
				begin
					next_st.sclk = 1'b0;
					if (master && st.filt[aop_pkg::PIN_RDC] && busy_rise)
					begin
						// Previous result goes out during the new conversion
						next_st.shreg = st.held; // R12
						next_st.bit_cnt = aop_pkg::BIT_COUNT;
						next_st.div_cnt = st.half;
						next_st.fsm = aop_pkg::ST_MASTER;
					end
					else if (master && !st.filt[aop_pkg::PIN_RDC] && result_valid_in)
					begin
						next_st.shreg = coded; // R12
						next_st.bit_cnt = aop_pkg::BIT_COUNT;
						next_st.div_cnt = st.half;
						next_st.fsm = aop_pkg::ST_MASTER;
					end
					else if (ser && st.filt[aop_pkg::PIN_SRC] && cs_fall)
					begin
						next_st.shreg = st.held; // R10
						next_st.bit_cnt = aop_pkg::BIT_COUNT;
						next_st.fsm = aop_pkg::ST_SLAVE;
					end
				end
				aop_pkg::ST_MASTER:
				begin
					if (!master)
					begin
						next_st.sclk = 1'b0;
						next_st.fsm = aop_pkg::ST_IDLE;
					end
					else if (st.div_cnt > 5'h01)
					begin
						next_st.div_cnt = st.div_cnt - 5'h01; // R11
					end
					else
					begin
						next_st.div_cnt = st.half;
						next_st.sclk = ~st.sclk; // R9
						if (st.sclk)
						begin
							next_st.shreg = {st.shreg[14:0], 1'b0}; // R13
							next_st.bit_cnt = st.bit_cnt - 5'h01;
							if (st.bit_cnt == 5'h01)
							begin
								next_st.fsm = aop_pkg::ST_IDLE;
							end
						end
					end
				end
				aop_pkg::ST_SLAVE:
				begin
					next_st.sclk = 1'b0;
					if (!ser || st.filt[aop_pkg::PIN_CS_N])
					begin
						next_st.fsm = aop_pkg::ST_IDLE;
					end
					else if (xclk_rise && st.bit_cnt != 5'h00)
					begin
						next_st.shreg = {st.shreg[14:0], 1'b0}; // R10 R13
						next_st.bit_cnt = st.bit_cnt - 5'h01;
					end
				end
				default:
				begin
					next_st.fsm = aop_pkg::ST_IDLE;
				end
			endcase

			// Pin drive
			if (!ser)
			begin
				next_st.bus_oe = aop_pkg::OE_ALL; // R1
				if (st.filt[aop_pkg::PIN_BYTE])
				begin
					next_st.bus_out = {st.held[7:0], st.held[15:8]}; // R3
				end
				else
				begin
					next_st.bus_out = st.held; // R3
				end
				next_st.sclk_oe = 1'b0;
			end
			else
			begin
				next_st.bus_oe = aop_pkg::OE_SERIAL; // R2 R5 R6 R8
				next_st.bus_oe[aop_pkg::LANE_SERIAL_RESULT_OUT] = master | ~st.filt[aop_pkg::PIN_CS_N];
				next_st.bus_out = 16'h0000;
				next_st.bus_out[1:0] = st.held[1:0]; // R5
				next_st.bus_out[aop_pkg::LANE_SERIAL_RESULT_OUT] = next_st.shreg[15]; // R13
				next_st.sclk_oe = master; // R9
			end
		end
	end

	always_ff @(posedge clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st <= '{fsm: aop_pkg::ST_IDLE, bus_oe: aop_pkg::OE_RESET,
				half: aop_pkg::SCLK_HALF_CYC_00, default: '0};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign data_bus_out = st.bus_out;
	assign data_bus_oe_out = st.bus_oe;
	assign serial_result_clock_out = st.sclk;
	assign serial_result_clock_oe_out = st.sclk_oe;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (reset_in);

	sequence s_master_rdc_start;
		enable_in && st.fsm == aop_pkg::ST_IDLE && master && st.filt[aop_pkg::PIN_RDC]
			&& busy_rise;
	endsequence
	sequence s_msb_loaded;
		st.shreg == $past(st.held) && st.fsm == aop_pkg::ST_MASTER;
	endsequence

	property p_parallel_drive;
		enable_in && !ser |=> data_bus_oe_out == aop_pkg::OE_ALL;
	endproperty
	a_parallel_drive: assert property (p_parallel_drive) // R1
		else $error("Parallel mode did not drive the whole bus");

	property p_serial_release;
		enable_in && ser |=> data_bus_oe_out[15:9] == 7'h00 && data_bus_oe_out[7:5] == 3'h0;
	endproperty
	a_serial_release: assert property (p_serial_release) // R2
		else $error("Unused bus pin driven in serial mode");

	property p_low_bits_out;
		data_bus_oe_out[1:0] == 2'b11;
	endproperty
	a_low_bits_out: assert property (p_low_bits_out) // R5
		else $error("Bus bits 0 and 1 not driven");

	property p_cfg_inputs;
		enable_in && ser |=> data_bus_oe_out[4:2] == 3'h0;
	endproperty
	a_cfg_inputs: assert property (p_cfg_inputs) // R6 R8
		else $error("Config pins driven in serial mode");

	property p_byte_order;
		enable_in && !ser && st.filt[aop_pkg::PIN_BYTE]
			|=> data_bus_out == {$past(st.held[7:0]), $past(st.held[15:8])};
	endproperty
	a_byte_order: assert property (p_byte_order) // R3
		else $error("Byte order swap wrong");

	property p_coding;
		enable_in && result_valid_in
			|=> st.held[15] == ($past(result_in[15]) ^ ~$past(st.filt[aop_pkg::PIN_CODE]));
	endproperty
	a_coding: assert property (p_coding) // R4
		else $error("Output coding of MSB wrong");

	property p_master_clock_drive;
		enable_in && master |=> serial_result_clock_oe_out;
	endproperty
	a_master_clock_drive: assert property (p_master_clock_drive) // R9
		else $error("Master mode not driving the serial clock");

	property p_clock_high_width;
		enable_in && $rose(serial_result_clock_out) |-> serial_result_clock_out[*4];
	endproperty
	a_clock_high_width: assert property (p_clock_high_width) // R11
		else $error("Serial clock high phase too short");

	property p_rdc_previous;
		s_master_rdc_start |=> s_msb_loaded;
	endproperty
	a_rdc_previous: assert property (p_rdc_previous) // R12
		else $error("Read during convert did not load previous result");

	property p_msb_first;
		enable_in && ser |=> data_bus_out[aop_pkg::LANE_SERIAL_RESULT_OUT] == st.shreg[15];
	endproperty
	a_msb_first: assert property (p_msb_first) // R13
		else $error("Serial data not showing shift register MSB");

	// Falling edge of the internal clock moves the next lower bit onto the data lane
	sequence s_master_fall;
		enable_in && st.fsm == aop_pkg::ST_MASTER && master && st.sclk
			&& st.div_cnt == 5'h01;
	endsequence

	property p_shift_order;
		s_master_fall |=> data_bus_out[aop_pkg::LANE_SERIAL_RESULT_OUT] == $past(st.shreg[14]);
	endproperty
	a_shift_order: assert property (p_shift_order) // R13
		else $error("Serial data did not advance to the next lower bit");

	property p_slave_load;
		enable_in && st.fsm == aop_pkg::ST_IDLE && ser && st.filt[aop_pkg::PIN_SRC] && cs_fall
			|=> data_bus_out[aop_pkg::LANE_SERIAL_RESULT_OUT] == $past(st.held[15])
			&& data_bus_oe_out[aop_pkg::LANE_SERIAL_RESULT_OUT];
	endproperty
	a_slave_load: assert property (p_slave_load) // R10 R13
		else $error("Slave frame did not start with the stored MSB");

	property p_enable_freeze;
		!enable_in |=> st == $past(st);
	endproperty
	a_enable_freeze: assert property (p_enable_freeze)
		else $error("State moved while the clock enable was low");

endmodule : aop_port

`default_nettype wire

// ---- aop_host.sv ----
// Host model for the result output port: bus lanes it drives and serial reads.
// Assumes it shares clk_in with the port and sees the port's bus drive and enables.
`timescale 1ns/10ps
`default_nettype none

module aop_host
(
	input wire logic clk_in,
	input wire logic [15:0] dev_bus_in,
	input wire logic [15:0] dev_oe_in,
	input wire logic dev_sclk_in,
	output logic [15:0] bus_in_out,
	output logic cs_n_out,
	output logic sclk_out
);
	logic [2:0] cfg;

	initial
	begin
		cfg = 3'h0;
		cs_n_out = 1'h1;
		sclk_out = 1'h0;
	end

	// Lanes nobody drives read back the inverse of the device value; undriven lanes 2 to 4 read the host config
	assign bus_in_out = (dev_oe_in & dev_bus_in) |
		(~dev_oe_in & {~dev_bus_in[15:5], cfg, ~dev_bus_in[1:0]});

	task set_cfg(input logic [1:0] div, input logic src);
		@(posedge clk_in);
		cfg <= {src, div};
	endtask : set_cfg

	// Host clock stands low outside the frame; each half is six cycles
	task slave_read(output logic [15:0] word);
		word = 16'h0000;
		@(posedge clk_in);
		cs_n_out <= 1'h0;
		repeat (8) @(posedge clk_in);
		repeat (16)
		begin
			repeat (6) @(posedge clk_in);
			word = {word[14:0], bus_in_out[8]};
			sclk_out <= 1'h1;
			repeat (6) @(posedge clk_in);
			sclk_out <= 1'h0;
		end
		repeat (6) @(posedge clk_in);
		cs_n_out <= 1'h1;
	endtask : slave_read

	task master_read(output logic [15:0] word, output int per);
		int n;
		int t;
		int t0;
		logic prev;
		word = 16'h0000;
		n = 0;
		t = 0;
		t0 = 0;
		per = 0;
		prev = dev_sclk_in;
		while (n < 16 && t < 2000)
		begin
			@(posedge clk_in);
			t++;
			if (dev_sclk_in && !prev)
			begin
				word = {word[14:0], bus_in_out[8]};
				if (n == 1)
					per = t - t0;
				t0 = t;
				n++;
			end
			prev = dev_sclk_in;
		end
		// Let the last high half and falling edge finish before selects move
		repeat (64) @(posedge clk_in);
	endtask : master_read
endmodule : aop_host

`default_nettype wire

// ---- aop_port_tb.sv ----
// Testbench for the result output port: parallel, serial master and slave reads.
// Assumes the port and the host model compile before it.
`timescale 1ns/10ps
`default_nettype none

module aop_port_tb;
	logic clk_in, reset_in, en, ser, byte_sel, code_sel, read_during_convert_select, valid, busy;
	logic sclk_out, sclk_oe, cs_n, host_sclk;
	logic [15:0] result, bus_in, bus_out, bus_oe, word, exp, v;
	int per, fails, n_tests;
	int mins[4] = '{aop_pkg::SCLK_MIN_PERIOD_NS_00, aop_pkg::SCLK_MIN_PERIOD_NS_01,
		aop_pkg::SCLK_MIN_PERIOD_NS_10, aop_pkg::SCLK_MIN_PERIOD_NS_11};

	aop_port u_dut (.clk_in(clk_in), .reset_in(reset_in), .enable_in(en),
		.serial_parallel_select_in(ser), .byte_order_select_in(byte_sel),
		.output_coding_select_in(code_sel), .read_during_convert_select_in(read_during_convert_select),
		.chip_select_n_in(cs_n), .result_in(result), .result_valid_in(valid),
		.conversion_busy_in(busy), .data_bus_in(bus_in), .data_bus_out(bus_out),
		.data_bus_oe_out(bus_oe), .serial_result_clock_in(host_sclk),
		.serial_result_clock_out(sclk_out), .serial_result_clock_oe_out(sclk_oe));

	aop_host u_host (.clk_in(clk_in), .dev_bus_in(bus_out), .dev_oe_in(bus_oe),
		.dev_sclk_in(sclk_out), .bus_in_out(bus_in), .cs_n_out(cs_n), .sclk_out(host_sclk));

	function automatic logic [15:0] coded(input logic [15:0] d, input logic straight);
		return straight ? d : d ^ 16'h8000;
	endfunction : coded

	task check(input string name, input logic [15:0] seen, input logic [15:0] want);
		n_tests++;
		if (seen !== want)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask : check

	task pulse(input logic [15:0] d);
		@(posedge clk_in);
		result <= d;
		valid <= 1'h1;
		@(posedge clk_in);
		valid <= 1'h0;
	endtask : pulse

	task final_report;
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	initial
	begin
		clk_in = 1'h0;
		forever #2 clk_in = ~clk_in;
	end

	// Whole run is well under ten thousand cycles
	initial
	begin
		#160000;
		fails++;
		$display("watchdog expired");
		final_report;
	end

	initial
	begin
		reset_in = 1'h1;
		en = 1'h1;
		ser = 1'h0;
		byte_sel = 1'h0;
		code_sel = 1'h1;
		read_during_convert_select = 1'h0;
		valid = 1'h0;
		busy = 1'h0;
		result = 16'h0000;
		fails = 0;
		n_tests = 0;
		repeat (12) @(posedge clk_in);
		check("reset enables", bus_oe, aop_pkg::OE_RESET);
		reset_in <= 1'h0;
		for (int i = 0; i < 4; i++)
		begin
			byte_sel <= i[0];
			code_sel <= i[1];
			repeat (6) @(posedge clk_in);
			pulse(16'ha51c);
			repeat (3) @(posedge clk_in);
			exp = coded(16'ha51c, i[1]);
			if (i[0])
				exp = {exp[7:0], exp[15:8]};
			check("parallel bus", bus_out, exp);
			check("parallel enables", bus_oe, aop_pkg::OE_ALL);
		end
		$display("test parallel done");
		en <= 1'h0;
		pulse(16'h5a5a);
		repeat (3) @(posedge clk_in);
		check("frozen bus", bus_out, exp);
		en <= 1'h1;
		$display("test clock enable done");
		ser <= 1'h1;
		code_sel <= 1'h0;
		for (int i = 0; i < 4; i++)
		begin
			u_host.set_cfg(i[1:0], 1'h0);
			repeat (40) @(posedge clk_in);
			check("serial enables", bus_oe & 16'hfeff, aop_pkg::OE_SERIAL);
			v = 16'h3c5a + 16'(i);
			pulse(v);
			u_host.master_read(word, per);
			check("master clock drive", 16'(sclk_oe), 16'h0001);
			check("master word", word, coded(v, 1'h0));
			check("period floor", 16'(per * 4 >= mins[i]), 16'h0001);
			check("period ceiling", 16'(per * 8 <= mins[i] * 3), 16'h0001);
		end
		$display("test serial master done");
		read_during_convert_select <= 1'h1;
		repeat (40) @(posedge clk_in);
		pulse(16'h0ff1);
		repeat (4) @(posedge clk_in);
		busy <= 1'h1;
		u_host.master_read(word, per);
		check("read during convert", word, coded(16'h0ff1, 1'h0));
		busy <= 1'h0;
		$display("test read during convert done");
		read_during_convert_select <= 1'h0;
		u_host.set_cfg(2'h0, 1'h1);
		repeat (40) @(posedge clk_in);
		pulse(16'hc3a7);
		repeat (8) @(posedge clk_in);
		check("slave clock drive", 16'(sclk_oe), 16'h0000);
		check("slave enables", bus_oe & 16'hfeff, aop_pkg::OE_SERIAL);
		u_host.slave_read(word);
		check("slave word", word, coded(16'hc3a7, 1'h0));
		$display("test serial slave done");
		ser <= 1'h0;
		repeat (8) @(posedge clk_in);
		check("parallel again", bus_oe, aop_pkg::OE_ALL);
		$display("test return to parallel done");
		final_report;
	end
endmodule : aop_port_tb

`default_nettype wire
